// >>> verification/rsp_host.sv
/* Host model: serial master driving rsp_port pins.
   Assumes the testbench calls its tasks; SCLK idles low. */
`timescale 1ns/1ps
module rsp_host (
	output logic      SCLK,
	output logic      SI,
	output logic      SELECT_LOW,
	input  wire logic SO
);
	// ****
	// Frames
	// ****
	// Clock stands low outside frames.
	initial begin
		SCLK = 1'b0;
		SI = 1'b0;
		SELECT_LOW = 1'b1;
	end
	// Select, then give the ready flag time before a rise.
	task automatic open_frame();
		SELECT_LOW = 1'b0;
		#100;
	endtask : open_frame
	// One byte MSB first; SO taken at each rise.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			SI = tx[i];
			#62.5 SCLK = 1'b1;
			rx[i] = SO;
			#62.5 SCLK = 1'b0;
		end
		// Released data shows the inverse, never a stale bit.
		SI = ~SI;
	endtask : xfer
	task automatic close_frame();
		#100 SELECT_LOW = 1'b1;
		#200;
	endtask : close_frame
endmodule : rsp_host

// >>> verification/tb.sv
/* Self-checking bench for rsp_port through the host model.
   Assumes rsp_pkg, rsp_port and rsp_host are compiled first. */
`timescale 1ns/1ps
module tb
	import rsp_pkg::*;
;
	logic       CLK, RESET, SCLK, SI, SELECT_LOW, SO;
	logic       CRYSTAL_READY_LOW, SLEEP_ENTER, RX_WR_VALID;
	logic       RX_WR_READY, STROBE_PULSE, SO_OE;
	logic [2:0] RADIO_STATE, st;
	logic [5:0] STROBE_CODE, code;
	logic [7:0] RX_WR_DATA, r, seed, q[$];
	logic [2:0] sts[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
	int         fails, checked, npul;
	rsp_port rsp_port_inst (.CLK(CLK), .RESET(RESET), .SCLK(SCLK),
		.SI(SI), .SELECT_LOW(SELECT_LOW), .SO(SO), .SO_OE(SO_OE),
		.CRYSTAL_READY_LOW(CRYSTAL_READY_LOW),
		.RADIO_STATE(RADIO_STATE), .SLEEP_ENTER(SLEEP_ENTER),
		.RX_WR_VALID(RX_WR_VALID), .RX_WR_READY(RX_WR_READY),
		.RX_WR_DATA(RX_WR_DATA), .STROBE_PULSE(STROBE_PULSE),
		.STROBE_CODE(STROBE_CODE));
	rsp_host rsp_host_inst (.SCLK(SCLK), .SI(SI),
		.SELECT_LOW(SELECT_LOW), .SO(SO));
	always #4 CLK = ~CLK;
	// Count strobes handed to the radio core.
	always @(posedge CLK) if (STROBE_PULSE === 1'b1) begin
		npul++;
		code = STROBE_CODE;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	// Status byte: ready flag, state, clipped fill count.
	function automatic logic [7:0] stat(input logic b,
		input logic [2:0] s, input int n);
		return {b, s, (n > 15) ? 4'hF : 4'(n)};
	endfunction : stat
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk_byte
	task automatic chk_cnt(input int g, input int e);
		checked++;
		if (g != e) begin
			fails++;
			$display("wrong value t=%0t strobes %0d exp %0d", $time, g, e);
		end
	endtask : chk_cnt
	task automatic hx(input logic [7:0] h, input logic [7:0] e);
		rsp_host_inst.xfer(h, r);
		chk_byte(r, e);
	endtask : hx
	// Read n data bytes against the expected queue.
	task automatic rd(input int n);
		repeat (n) hx(8'h00, q.pop_front());
	endtask : rd
	// Hold valid across pushes; the FIFO never refuses below depth.
	task automatic push(input int n);
		repeat (n) begin
			seed = lfsr(seed);
			q.push_back(seed);
			RX_WR_DATA = seed;
			RX_WR_VALID = 1'b1;
			@(posedge CLK) #1;
		end
		RX_WR_VALID = 1'b0;
	endtask : push
	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : wt
	task automatic wrap_up();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up
	// A hang counts as a mismatch.
	initial begin
		#400000;
		fails++;
		wrap_up();
	end
	initial begin
		CLK = 1'b0;
		RESET = 1'b1;
		CRYSTAL_READY_LOW = 1'b1;
		RADIO_STATE = RSP_ST_IDLE;
		SLEEP_ENTER = 1'b0;
		RX_WR_VALID = 1'b0;
		RX_WR_DATA = 8'h00;
		seed = 8'h33;
		repeat (4) @(posedge CLK);
		#1 RESET = 1'b0;
		wt(4);
		rsp_host_inst.open_frame();
		chk_byte({7'h00, SO_OE}, 8'h01);
		hx(8'h80, stat(1'b1, RSP_ST_IDLE, 0));
		hx(8'h00, 8'h00);
		rsp_host_inst.close_frame();
		chk_byte({7'h00, SO_OE}, 8'h00);
		CRYSTAL_READY_LOW = 1'b0;
		// Burst write ending past the last config address.
		rsp_host_inst.open_frame();
		hx(8'h6C, stat(1'b0, RSP_ST_IDLE, 0));
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			q.push_back(seed);
			hx(seed, stat(1'b0, RSP_ST_IDLE, 0));
		end
		hx(8'hA5, stat(1'b0, RSP_ST_IDLE, 0));
		rsp_host_inst.close_frame();
		rsp_host_inst.open_frame();
		hx(8'hEC, stat(1'b0, RSP_ST_IDLE, 0));
		rd(3);
		hx(8'h00, 8'h00);
		rsp_host_inst.close_frame();
		// Receive FIFO: single reads, fill to refusal, burst drain.
		st = sts[seed % 5];
		RADIO_STATE = st;
		push(5);
		rsp_host_inst.open_frame();
		hx(8'hBF, stat(1'b0, st, 5));
		rd(1);
		hx(8'hBF, stat(1'b0, st, 4));
		rd(1);
		rsp_host_inst.close_frame();
		push(61);
		chk_byte({7'h0, RX_WR_READY}, 8'h00);
		rsp_host_inst.open_frame();
		hx(8'hFF, stat(1'b0, st, 64));
		rd(64);
		rsp_host_inst.close_frame();
		// Strobes: refused flush, status registers, go-idle block.
		RADIO_STATE = RSP_ST_RX;
		push(2);
		rsp_host_inst.open_frame();
		hx(8'hBA, stat(1'b0, RSP_ST_RX, 2));
		hx(8'hB4, stat(1'b0, RSP_ST_RX, 2));
		hx(8'hF5, stat(1'b0, RSP_ST_RX, 2));
		hx(8'h00, 8'h01);
		hx(8'hF5, stat(1'b0, RSP_ST_RX, 2));
		hx(8'h00, 8'h01);
		hx(8'hFB, stat(1'b0, RSP_ST_RX, 2));
		hx(8'h00, 8'h02);
		rsp_host_inst.close_frame();
		chk_cnt(npul, 1);
		chk_byte({2'b00, code}, 8'h34);
		rsp_host_inst.open_frame();
		hx(8'hB6, stat(1'b0, RSP_ST_RX, 2));
		hx(8'hB4, stat(1'b0, RSP_ST_RX, 2));
		rsp_host_inst.close_frame();
		chk_cnt(npul, 2);
		RADIO_STATE = RSP_ST_IDLE;
		wt(4);
		rsp_host_inst.open_frame();
		hx(8'hBA, stat(1'b0, RSP_ST_IDLE, 2));
		rsp_host_inst.close_frame();
		q.delete();
		rsp_host_inst.open_frame();
		hx(8'hB9, stat(1'b0, RSP_ST_IDLE, 0));
		wt(20);
		chk_cnt(npul, 3);
		rsp_host_inst.close_frame();
		chk_cnt(npul, 4);
		chk_byte({2'b00, code}, 8'h39);
		// Sleep entry empties the FIFO.
		push(1);
		SLEEP_ENTER = 1'b1;
		wt(1);
		SLEEP_ENTER = 1'b0;
		rsp_host_inst.open_frame();
		hx(8'hBF, stat(1'b0, RSP_ST_IDLE, 0));
		hx(8'h00, 8'h00);
		rsp_host_inst.close_frame();
		// Overrun: read what is useful, flush, then a chip reset.
		q.delete();
		push(2);
		RADIO_STATE = RSP_ST_OVERRUN;
		rsp_host_inst.open_frame();
		hx(8'hBF, stat(1'b0, RSP_ST_OVERRUN, 2));
		rd(1);
		hx(8'hBA, stat(1'b0, RSP_ST_OVERRUN, 1));
		hx(8'hBF, stat(1'b0, RSP_ST_OVERRUN, 0));
		hx(8'h00, 8'h00);
		hx(8'hB0, stat(1'b0, RSP_ST_OVERRUN, 0));
		for (int i = 0; i < 50 && SO !== 1'b0; i++) begin
			wt(1);
		end
		chk_byte({7'h00, SO}, 8'h00);
		rsp_host_inst.close_frame();
		chk_cnt(npul, 6);
		chk_byte({2'b00, code}, 8'h30);
		wrap_up();
	end
endmodule : tb

// >>> verilog/rsp_cfg_mem.sv
/*
 * Configuration register file: one write port, registered read data.
 * Assumes writes and reads come from the serial port on CLK.
 */
`timescale 1ns/1ps
module rsp_cfg_mem
	import rsp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       we,
	input  wire logic [5:0] addr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata
);
	logic [7:0] mem_reg [RSP_CFG_WORDS];
	logic       in_map;

	// Addresses above the last configuration word read back zero.
	assign in_map = (addr <= RSP_CFG_LAST);

	// ****************************************************************
	// Storage and read register
	// ****************************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < RSP_CFG_WORDS; i++) begin
				mem_reg[i] <= RSP_BYTE_RESET;
			end
			rdata <= RSP_BYTE_RESET;
		end else begin
			if (we && in_map) begin
				mem_reg[addr] <= wdata;
			end
			rdata <= in_map ? mem_reg[addr] : RSP_BYTE_RESET;
		end
	end
endmodule : rsp_cfg_mem

// >>> verilog/rsp_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides, a flush input and
 * a fill count. Assumes one clock for both sides.
 */
`timescale 1ns/1ps
module rsp_fifo #(
	parameter int W = 8,
	parameter int D = 64
) (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               flush,
	input  wire logic               wr_valid,
	output logic                    wr_ready,
	input  wire logic [W-1:0]       wr_data,
	output logic                    rd_valid,
	input  wire logic               rd_ready,
	output logic      [W-1:0]       rd_data,
	output logic      [$clog2(D):0] count
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_reg [D];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0]   cnt_reg;
	logic          push;
	logic          pop;

	// Full refuses the writer, so back-pressure reaches the source.
	assign wr_ready = (cnt_reg != (AW+1)'(D));
	assign rd_valid = (cnt_reg != '0);
	assign push     = wr_valid && wr_ready && !flush;
	assign pop      = rd_valid && rd_ready && !flush;
	assign rd_data  = mem_reg[rp_reg];
	assign count    = cnt_reg;

	// ****************************************************************
	// Pointers and count
	// ****************************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else if (flush) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg  <= push ? wp_reg + 1'b1 : wp_reg;
			rp_reg  <= pop ? rp_reg + 1'b1 : rp_reg;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage carries no reset; only the pointers define contents.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wp_reg] <= wr_data;
		end
	end
endmodule : rsp_fifo

// >>> verilog/rsp_pkg.sv
/*
 * Constants and types shared by the radio serial port block: header
 * decoding, status byte layout, main state codes, strobe codes and
 * reset values.
 * Assumes a single crystal clock domain; the serial pins are sampled.
 */
package rsp_pkg;

	// ****************************************************************
	// Widths and depths
	// ****************************************************************
	localparam int RSP_DATA_W     = 8;
	localparam int RSP_ADDR_W     = 6;
	localparam int RSP_FIFO_DEPTH = 64;
	localparam int RSP_CNT_W      = 7;
	localparam int RSP_CFG_WORDS  = 47;

	// ****************************************************************
	// Address map (six-bit header addresses)
	// ****************************************************************
	localparam logic [5:0] RSP_CFG_FIRST       = 6'h00;
	localparam logic [5:0] RSP_CFG_LAST        = 6'h2E;
	localparam logic [5:0] RSP_STROBE_FIRST    = 6'h30;
	localparam logic [5:0] RSP_STROBE_LAST     = 6'h3D;
	localparam logic [5:0] RSP_RX_FIFO_PORT    = 6'h3F;
	localparam logic [5:0] RSP_RADIO_STATE_STATUS = 6'h35;
	localparam logic [5:0] RSP_RX_COUNT_STATUS    = 6'h3B;

	// ****************************************************************
	// Strobe codes
	// ****************************************************************
	localparam logic [5:0] RSP_CHIP_RESET_STROBE    = 6'h30;
	localparam logic [5:0] RSP_OSCILLATOR_OFF_STROBE = 6'h32;
	localparam logic [5:0] RSP_GO_IDLE_STROBE       = 6'h36;
	localparam logic [5:0] RSP_POWER_DOWN_STROBE    = 6'h39;
	localparam logic [5:0] RSP_RX_FLUSH_STROBE      = 6'h3A;

	// ****************************************************************
	// Header and status byte fields
	// ****************************************************************
	localparam int RSP_HDR_RW_BIT    = 7;
	localparam int RSP_HDR_BURST_BIT = 6;
	localparam int RSP_STAT_RDY_BIT  = 7;
	localparam int RSP_STAT_ST_LSB   = 4;
	localparam logic [3:0] RSP_COUNT_SAT = 4'hF;
	localparam logic [2:0] RSP_LAST_BIT  = 3'h7;

	// ****************************************************************
	// Main state codes reported in the status byte
	// ****************************************************************
	localparam logic [2:0] RSP_ST_IDLE    = 3'h0;
	localparam logic [2:0] RSP_ST_RX      = 3'h1;
	localparam logic [2:0] RSP_ST_CAL     = 3'h4;
	localparam logic [2:0] RSP_ST_SETTLE  = 3'h5;
	localparam logic [2:0] RSP_ST_OVERRUN = 3'h6;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RSP_BYTE_RESET = 8'h00;
	localparam logic [7:0] RSP_TX_RESET   = 8'h80;
	localparam logic [5:0] RSP_ADDR_RESET = 6'h00;

	// Protocol phase of the serial port.
	typedef enum logic [2:0] {
		RSP_PH_HEAD = 3'b001,
		RSP_PH_REG  = 3'b010,
		RSP_PH_FIFO = 3'b100
	} rsp_phase_t;

	// Source of the byte returned during a read data byte.
	typedef enum logic [2:0] {
		RSP_RD_CFG  = 3'b001,
		RSP_RD_STAT = 3'b010,
		RSP_RD_FIFO = 3'b100
	} rsp_rdsrc_t;

	// True when an address lies inside an inclusive range.
	function automatic logic rsp_in_range(input logic [5:0] a,
		input logic [5:0] lo, input logic [5:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : rsp_in_range

	// Fill count clipped to the four-bit status field.
	function automatic logic [3:0] rsp_sat_count(
		input logic [RSP_CNT_W-1:0] c);
		return (c >= RSP_CNT_W'(RSP_COUNT_SAT)) ? RSP_COUNT_SAT : c[3:0];
	endfunction : rsp_sat_count

endpackage : rsp_pkg

// >>> verilog/rsp_port.sv
/*
 * Serial slave port of the receiver: status byte on every header,
 * configuration access with burst auto-increment, status registers,
 * command strobes and reads of the 64-byte receive FIFO.
 * Assumes the radio core sits on CLK and reports its state, crystal
 * readiness and received bytes; serial pins come from the host.
 */
// Behaviour
// - Status byte shifts out during headers and writes.
// - Bit 7 high until crystal is ready.
// - Bits 6:4 carry the main state code.
// - Bits 3:0 saturating receive FIFO byte count.
// - Configuration 0x00-0x2E writable and readable.
// - Reads return data after the header byte.
// - Burst counter increments per byte until deselect.
// - Burst bit splits status registers from strobes.
// - Go-idle cancels and blocks strobes until idle.
// - Power-down, oscillator-off wait for deselect.
// - FIFO read at 0x3F, burst or single.
// - Single FIFO read returns to header.
// - Flush only in idle or overrun; sleep flushes.
// - Deselect mid-byte cancels without effect.
// - Header is rw, burst, address; MSB first.
`timescale 1ns/1ps
module rsp_port
	import rsp_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       RESET,
	input  wire logic       SCLK,
	input  wire logic       SI,
	input  wire logic       SELECT_LOW,
	output logic            SO,
	output logic            SO_OE,
	input  wire logic       CRYSTAL_READY_LOW,
	input  wire logic [2:0] RADIO_STATE,
	input  wire logic       SLEEP_ENTER,
	input  wire logic       RX_WR_VALID,
	output logic            RX_WR_READY,
	input  wire logic [7:0] RX_WR_DATA,
	output logic            STROBE_PULSE,
	output logic      [5:0] STROBE_CODE
);
	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
	logic si_s1_reg, si_s2_reg;
	logic sel_s1_reg, sel_s2_reg, sel_s3_reg;

	// Two flops per pin; the third sclk and select flops only feed
	// edge detection, never the first stage.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			{sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= 3'h0;
			{si_s1_reg, si_s2_reg} <= 2'h0;
			{sel_s1_reg, sel_s2_reg, sel_s3_reg} <= 3'h7;
		end else begin
			{sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <=
				{SCLK, sclk_s1_reg, sclk_s2_reg};
			{si_s1_reg, si_s2_reg} <= {SI, si_s1_reg};
			{sel_s1_reg, sel_s2_reg, sel_s3_reg} <=
				{SELECT_LOW, sel_s1_reg, sel_s2_reg};
		end
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic        selected, sel_rise, sclk_rise, sclk_fall;
	logic [2:0]  bit_cnt_reg, bit_cnt_next;
	logic [6:0]  rx_sh_reg;
	logic        byte_done;
	logic [7:0]  byte_in;
	logic        hd_rw, hd_burst;
	logic [5:0]  hd_addr;
	logic        is_cfg, is_strb, is_stat, is_fifo;
	rsp_phase_t  phase_reg, phase_next;
	rsp_rdsrc_t  rdsrc_reg, rdsrc_next;
	logic [5:0]  addr_reg, addr_next;
	logic        burst_reg, burst_next;
	logic        rw_reg, rw_next;
	logic        rdmode_reg, rdmode_next;
	logic        ld1_reg, ld2_reg;
	logic [7:0]  tx_reg, tx_next;
	logic [7:0]  status_byte, rd_byte, stat_rd_reg, fifo_byte_reg;
	logic        cfg_we;
	logic [7:0]  cfg_rdata;
	logic        fifo_pop, fifo_valid, fifo_flush;
	logic [7:0]  fifo_dout;
	logic [RSP_CNT_W-1:0] fifo_count;
	logic        strb_hit, strb_blocked, strb_deferred, strb_flush_ok;
	logic        idle_wait_reg, pend_pd_reg, pend_xoff_reg;
	logic        flush_strb_reg;

	// ****************************************************************
	// Serial bit engine
	// ****************************************************************
	// Edges come from the synchronised copies only.
	assign selected  = !sel_s2_reg;
	assign sel_rise  = sel_s2_reg && !sel_s3_reg;
	assign sclk_rise = sclk_s2_reg && !sclk_s3_reg;
	assign sclk_fall = !sclk_s2_reg && sclk_s3_reg;
	assign byte_done = selected && sclk_rise && (bit_cnt_reg == RSP_LAST_BIT);
	assign byte_in   = {rx_sh_reg, si_s2_reg};
	assign bit_cnt_next = !selected ? 3'h0 :
		(sclk_rise ? bit_cnt_reg + 3'h1 : bit_cnt_reg);

	// A deselect clears the bit counter, so a partial byte is lost.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			bit_cnt_reg <= 3'h0;
			rx_sh_reg   <= 7'h00;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			if (selected && sclk_rise) begin
				rx_sh_reg <= byte_in[6:0];
			end
		end
	end

	// ****************************************************************
	// Header decode
	// ****************************************************************
	assign hd_rw    = byte_in[RSP_HDR_RW_BIT];
	assign hd_burst = byte_in[RSP_HDR_BURST_BIT];
	assign hd_addr  = byte_in[RSP_ADDR_W-1:0];
	assign is_cfg   = rsp_in_range(hd_addr, RSP_CFG_FIRST, RSP_CFG_LAST);
	assign is_strb  = !hd_burst &&
		rsp_in_range(hd_addr, RSP_STROBE_FIRST, RSP_STROBE_LAST);
	assign is_stat  = hd_burst &&
		rsp_in_range(hd_addr, RSP_STROBE_FIRST, RSP_STROBE_LAST);
	assign is_fifo  = hd_rw && (hd_addr == RSP_RX_FIFO_PORT);

	// Phase, address counter and read source for the next byte.
	always_comb begin
		phase_next  = phase_reg;
		addr_next   = addr_reg;
		burst_next  = burst_reg;
		rw_next     = rw_reg;
		rdmode_next = rdmode_reg;
		rdsrc_next  = rdsrc_reg;
		if (!selected) begin
			phase_next  = RSP_PH_HEAD;
			rdmode_next = 1'b0;
		end else if (byte_done) begin
			unique case (phase_reg)
				RSP_PH_HEAD: begin
					addr_next   = hd_addr;
					burst_next  = hd_burst && !is_stat;
					rw_next     = hd_rw;
					rdmode_next = hd_rw && !is_strb;
					rdsrc_next  = is_fifo ? RSP_RD_FIFO :
						(is_stat ? RSP_RD_STAT : RSP_RD_CFG);
					phase_next  = is_strb ? RSP_PH_HEAD :
						(is_fifo ? RSP_PH_FIFO : RSP_PH_REG);
				end
				RSP_PH_REG: begin
					addr_next   = addr_reg + 6'h01;
					phase_next  = burst_reg ? RSP_PH_REG : RSP_PH_HEAD;
					rdmode_next = burst_reg && rw_reg;
				end
				RSP_PH_FIFO: begin
					phase_next  = burst_reg ? RSP_PH_FIFO : RSP_PH_HEAD;
					rdmode_next = burst_reg;
				end
				default: begin
					phase_next  = RSP_PH_HEAD;
					rdmode_next = 1'b0;
				end
			endcase
		end
	end

	// Protocol registers.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			phase_reg  <= RSP_PH_HEAD;
			addr_reg   <= RSP_ADDR_RESET;
			burst_reg  <= 1'b0;
			rw_reg     <= 1'b0;
			rdmode_reg <= 1'b0;
			rdsrc_reg  <= RSP_RD_CFG;
		end else begin
			phase_reg  <= phase_next;
			addr_reg   <= addr_next;
			burst_reg  <= burst_next;
			rw_reg     <= rw_next;
			rdmode_reg <= rdmode_next;
			rdsrc_reg  <= rdsrc_next;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Writes land only on a completed data byte of a write access.
	assign cfg_we = byte_done && (phase_reg == RSP_PH_REG) && !rw_reg &&
		(rdsrc_reg == RSP_RD_CFG) && (addr_reg <= RSP_CFG_LAST);

	rsp_cfg_mem u_cfg (
		.clk   (CLK),
		.reset (RESET),
		.we    (cfg_we),
		.addr  (addr_reg),
		.wdata (byte_in),
		.rdata (cfg_rdata)
	);

	// ****************************************************************
	// Receive FIFO
	// ****************************************************************
	// One byte leaves on each FIFO header or burst byte boundary.
	assign fifo_pop = byte_done && (rdmode_next && rdsrc_next == RSP_RD_FIFO);
	assign fifo_flush = flush_strb_reg || SLEEP_ENTER;

	rsp_fifo #(
		.W (RSP_DATA_W),
		.D (RSP_FIFO_DEPTH)
	) u_fifo (
		.clk      (CLK),
		.reset    (RESET),
		.flush    (fifo_flush),
		.wr_valid (RX_WR_VALID),
		.wr_ready (RX_WR_READY),
		.wr_data  (RX_WR_DATA),
		.rd_valid (fifo_valid),
		.rd_ready (fifo_pop),
		.rd_data  (fifo_dout),
		.count    (fifo_count)
	);

	// Captures of FIFO head and status register contents; an empty
	// FIFO reads as zero rather than stale storage.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			fifo_byte_reg <= RSP_BYTE_RESET;
			stat_rd_reg   <= RSP_BYTE_RESET;
		end else if (byte_done) begin
			fifo_byte_reg <= fifo_valid ? fifo_dout : RSP_BYTE_RESET;
			stat_rd_reg   <= (hd_addr == RSP_RADIO_STATE_STATUS) ?
				{5'h00, RADIO_STATE} :
				(hd_addr == RSP_RX_COUNT_STATUS) ?
				{1'b0, fifo_count} : RSP_BYTE_RESET;
		end
	end

	// ****************************************************************
	// Status byte and output shifter
	// ****************************************************************
	assign status_byte = {CRYSTAL_READY_LOW, RADIO_STATE,
		rsp_sat_count(fifo_count)};
	assign rd_byte = (rdsrc_reg == RSP_RD_FIFO) ? fifo_byte_reg :
		(rdsrc_reg == RSP_RD_STAT) ? stat_rd_reg : cfg_rdata;

	// Read data is loaded two cycles after the byte boundary, when
	// the registered configuration read has caught the new address.
	// Between bytes the status byte is refreshed so that bit 7 tracks
	// the crystal right up to the first rising edge. While deselected
	// it follows the status byte too, so a cut byte leaves nothing stale.
	assign tx_next = !selected ? status_byte :
		ld2_reg ? (rdmode_reg ? rd_byte : status_byte) :
		(selected && sclk_fall && bit_cnt_reg != 3'h0) ?
		{tx_reg[6:0], 1'b0} :
		((bit_cnt_reg == 3'h0) && !rdmode_reg && !ld1_reg) ?
		status_byte : tx_reg;

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tx_reg  <= RSP_TX_RESET;
			ld1_reg <= 1'b0;
			ld2_reg <= 1'b0;
		end else begin
			tx_reg  <= tx_next;
			ld1_reg <= byte_done;
			ld2_reg <= ld1_reg && selected;
		end
	end

	assign SO    = tx_reg[7];
	assign SO_OE = selected;

	// ****************************************************************
	// Command strobes
	// ****************************************************************
	assign strb_hit = byte_done && (phase_reg == RSP_PH_HEAD) && is_strb;
	assign strb_blocked = idle_wait_reg;
	assign strb_deferred = (hd_addr == RSP_POWER_DOWN_STROBE) ||
		(hd_addr == RSP_OSCILLATOR_OFF_STROBE);
	assign strb_flush_ok = (RADIO_STATE == RSP_ST_IDLE) ||
		(RADIO_STATE == RSP_ST_OVERRUN);

	// A go-idle wait clears once the core reports idle; a new go-idle
	// in that cycle is still blocked and does not set it again.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			idle_wait_reg  <= 1'b0;
			pend_pd_reg    <= 1'b0;
			pend_xoff_reg  <= 1'b0;
			flush_strb_reg <= 1'b0;
			STROBE_PULSE   <= 1'b0;
			STROBE_CODE    <= RSP_ADDR_RESET;
		end else begin
			STROBE_PULSE   <= 1'b0;
			flush_strb_reg <= 1'b0;
			if (idle_wait_reg && RADIO_STATE == RSP_ST_IDLE) begin
				idle_wait_reg <= 1'b0;
			end
			if (sel_rise && (pend_pd_reg || pend_xoff_reg)) begin
				STROBE_PULSE  <= 1'b1;
				STROBE_CODE   <= pend_pd_reg ? RSP_POWER_DOWN_STROBE :
					RSP_OSCILLATOR_OFF_STROBE;
				pend_pd_reg   <= 1'b0;
				pend_xoff_reg <= 1'b0;
			end else if (strb_hit && !strb_blocked) begin
				if (hd_addr == RSP_GO_IDLE_STROBE) begin
					idle_wait_reg <= 1'b1;
					pend_pd_reg   <= 1'b0;
					pend_xoff_reg <= 1'b0;
					STROBE_PULSE  <= 1'b1;
					STROBE_CODE   <= hd_addr;
				end else if (strb_deferred) begin
					pend_pd_reg   <= pend_pd_reg ||
						(hd_addr == RSP_POWER_DOWN_STROBE);
					pend_xoff_reg <= pend_xoff_reg ||
						(hd_addr == RSP_OSCILLATOR_OFF_STROBE);
				end else if (hd_addr == RSP_RX_FLUSH_STROBE) begin
					flush_strb_reg <= strb_flush_ok;
					STROBE_PULSE   <= strb_flush_ok;
					STROBE_CODE    <= hd_addr;
				end else begin
					STROBE_PULSE <= 1'b1;
					STROBE_CODE  <= hd_addr;
				end
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	status_shift_a: assert property (!selected |=>
		tx_reg == $past(status_byte))
		else $error("status byte not presented while deselected");
	ready_bit_a: assert property (!selected ##1 !selected |->
		SO == $past(CRYSTAL_READY_LOW))
		else $error("ready flag not on serial output");
	count_sat_a: assert property ((fifo_count > 7'd15) |->
		status_byte[3:0] == 4'hF)
		else $error("fill count does not saturate");
	cfg_write_a: assert property (cfg_we |->
		(addr_reg <= RSP_CFG_LAST) ##1
		(u_cfg.mem_reg[$past(addr_reg)] == $past(byte_in)))
		else $error("configuration write did not land");
	read_load_a: assert property (byte_done && rdmode_next && selected
		##2 selected |=> tx_reg == $past(rd_byte))
		else $error("read data not loaded after header");
	burst_incr_a: assert property (byte_done &&
		phase_reg == RSP_PH_REG |=> addr_reg == $past(addr_reg) + 6'h01)
		else $error("burst address did not increment");
	idle_block_a: assert property (strb_hit && idle_wait_reg |=>
		!STROBE_PULSE)
		else $error("strobe accepted during go-idle wait");
	defer_pd_a: assert property (STROBE_PULSE &&
		STROBE_CODE == RSP_POWER_DOWN_STROBE |-> $past(sel_rise))
		else $error("power-down strobe not deferred to deselect");
	single_fifo_a: assert property (byte_done && !burst_reg &&
		phase_reg == RSP_PH_FIFO |=> phase_reg == RSP_PH_HEAD)
		else $error("single FIFO read did not return to header");
	flush_gate_a: assert property (flush_strb_reg |->
		$past(strb_flush_ok))
		else $error("flush accepted outside idle or overrun");
	cancel_a: assert property ($rose(sel_s2_reg) |=>
		bit_cnt_reg == 3'h0 && phase_reg == RSP_PH_HEAD)
		else $error("deselect did not cancel transfer");

	burst_read_c: cover property (byte_done && burst_reg && rw_reg &&
		phase_reg == RSP_PH_REG);
	fifo_burst_c: cover property (fifo_pop && phase_reg == RSP_PH_FIFO);
	strobe_c: cover property (STROBE_PULSE &&
		STROBE_CODE == RSP_GO_IDLE_STROBE);
endmodule : rsp_port
